// [verilog/mfi_top.sv]
// Purpose: flag latching, masking and interrupt pin of module management
// Assumes: all pins synchronous to CORE_CLK, AXI4-Lite register access
// Notes: flags clear on read or by writing ones; a new event wins
`timescale 1ns/1ps
`default_nettype none
module mfi_top #(
  parameter int TICK_CYCLES = mfi_pkg::MS_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [mfi_pkg::ADDR_W-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [mfi_pkg::ADDR_W-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic MODULE_RESET_N,
  input wire logic RX_LOS_RAW,
  input wire logic TX_FAULT_RAW,
  input wire logic [mfi_pkg::NUM_OTHER-1:0] FLAG_COND,
  input wire logic INTERRUPT_OUT_N_I,
  output logic INTERRUPT_OUT_N_O,
  output logic INTERRUPT_OUT_N_OE,
  output logic MODULE_PRESENT_N,
  output logic MANAGEMENT_INIT_STATE,
  output logic TX_ENABLE
);
  localparam int NF = mfi_pkg::NUM_FLAGS;
  localparam int NO = mfi_pkg::NUM_OTHER;
  localparam int CW = mfi_pkg::CNT_W;
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_h;
    logic w_h;
    logic bvalid;
    logic [1:0] bresp;
    logic [mfi_pkg::ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wbe;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [NF-1:0] flag;
    logic [NF-1:0] mask;
    logic tx_dis;
    logic fast_los;
    logic los_prev;
    logic txf_prev;
    logic [NO-1:0] oth_prev;
    logic init_done;
    logic init_busy;
    logic [CW-1:0] init_cnt;
    logic tx_on;
    logic [CW-1:0] txen_cnt;
    logic irq_oe;
    logic irq_lvl;
    logic pres_n;
  } mfi_top_st_t;
  localparam mfi_top_st_t S_RST = '{
    awrdy: 1'b1,
    wrdy: 1'b1,
    arrdy: 1'b1,
    mask: mfi_pkg::MASK_RST,
    init_busy: 1'b1,
    default: '0
  };
  mfi_top_st_t s_ff;
  mfi_top_st_t nxt_s;
  logic tick;
  logic los_q;
  logic [CW-1:0] los_on_lim;
  logic wr_go;
  logic ar_hs;
  logic [NF-1:0] set_v;
  logic [NF-1:0] rd_clr;
  logic [NF-1:0] wr_clr;
  logic [7:0] st_v;

  mfi_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .core_clk(CORE_CLK),
    .nrst(NRST),
    .tick(tick)
  );

  // Fast mode only shortens the assert filter, release keeps its hysteresis
  assign los_on_lim = s_ff.fast_los ? mfi_pkg::LOS_FAST_TICKS
                                    : mfi_pkg::LOS_ON_TICKS;

  mfi_qual #(
    .CNT_W(CW)
  ) u_los (
    .core_clk(CORE_CLK),
    .nrst(NRST),
    .clr(!MODULE_RESET_N),
    .tick(tick),
    .raw(RX_LOS_RAW),
    .on_ticks(los_on_lim),
    .off_ticks(mfi_pkg::LOS_OFF_TICKS),
    .q(los_q)
  );

  always_comb begin
    nxt_s = s_ff;
    wr_go = s_ff.aw_h & s_ff.w_h & ~s_ff.bvalid;
    ar_hs = ARVALID & s_ff.arrdy;
    rd_clr = '0;
    wr_clr = '0;
    st_v = '0;
    st_v[mfi_pkg::ST_INIT] = s_ff.init_done;
    st_v[mfi_pkg::ST_TXON] = s_ff.tx_on;
    st_v[mfi_pkg::ST_LOS] = los_q;
    st_v[mfi_pkg::ST_PIN] = INTERRUPT_OUT_N_I;
    // Edge latching keeps a standing condition from re-arming after a read
    set_v = '0;
    set_v[mfi_pkg::FLAG_LOS] = los_q & ~s_ff.los_prev;
    set_v[mfi_pkg::FLAG_TXF] = TX_FAULT_RAW & ~s_ff.txf_prev;
    set_v[NF-1:mfi_pkg::FLAG_OTH] = FLAG_COND & ~s_ff.oth_prev;
    nxt_s.los_prev = los_q;
    nxt_s.txf_prev = TX_FAULT_RAW;
    nxt_s.oth_prev = FLAG_COND;

    if (AWVALID && s_ff.awrdy) begin
      nxt_s.aw_h = 1'b1;
      nxt_s.awrdy = 1'b0;
      nxt_s.awaddr = AWADDR;
    end
    if (WVALID && s_ff.wrdy) begin
      nxt_s.w_h = 1'b1;
      nxt_s.wrdy = 1'b0;
      nxt_s.wdata = WDATA[7:0];
      nxt_s.wbe = WSTRB[0];
    end
    if (wr_go) begin
      nxt_s.aw_h = 1'b0;
      nxt_s.w_h = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = mfi_pkg::RESP_OKAY;
      case (s_ff.awaddr[4:2])
        mfi_pkg::IDX_FLAG: begin
          if (s_ff.wbe) begin
            wr_clr = s_ff.wdata;
          end
        end
        mfi_pkg::IDX_MASK: begin
          if (s_ff.wbe) begin
            nxt_s.mask = s_ff.wdata;
          end
        end
        mfi_pkg::IDX_CTRL: begin
          if (s_ff.wbe) begin
            nxt_s.tx_dis = s_ff.wdata[mfi_pkg::CTRL_TXDIS];
            nxt_s.fast_los = s_ff.wdata[mfi_pkg::CTRL_FAST];
          end
        end
        mfi_pkg::IDX_STATE: begin
          nxt_s.bresp = mfi_pkg::RESP_OKAY;
        end
        default: begin
          nxt_s.bresp = mfi_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_ff.bvalid && BREADY) begin
      nxt_s.bvalid = 1'b0;
      nxt_s.awrdy = 1'b1;
      nxt_s.wrdy = 1'b1;
    end

    if (ar_hs) begin
      nxt_s.arrdy = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = mfi_pkg::RESP_OKAY;
      case (ARADDR[4:2])
        mfi_pkg::IDX_FLAG: begin
          nxt_s.rdata = s_ff.flag;
          rd_clr = s_ff.flag;
        end
        mfi_pkg::IDX_MASK: begin
          nxt_s.rdata = s_ff.mask;
        end
        mfi_pkg::IDX_CTRL: begin
          nxt_s.rdata = '0;
          nxt_s.rdata[mfi_pkg::CTRL_TXDIS] = s_ff.tx_dis;
          nxt_s.rdata[mfi_pkg::CTRL_FAST] = s_ff.fast_los;
        end
        mfi_pkg::IDX_STATE: begin
          nxt_s.rdata = st_v;
        end
        default: begin
          nxt_s.rdata = '0;
          nxt_s.rresp = mfi_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_ff.rvalid && RREADY) begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arrdy = 1'b1;
    end

    // Set is ORed last so an event in the clearing cycle survives
    nxt_s.flag = (s_ff.flag & ~(rd_clr | wr_clr)) | set_v;

    if (!s_ff.init_done && tick) begin
      if (s_ff.init_cnt >= mfi_pkg::INIT_TICKS - 1'b1) begin
        nxt_s.init_done = 1'b1;
      end else begin
        nxt_s.init_cnt = s_ff.init_cnt + 1'b1;
      end
    end

    // Module reset pin restarts init; the host keeps it low long enough
    if (!MODULE_RESET_N) begin
      nxt_s.flag = '0;
      nxt_s.mask = mfi_pkg::MASK_RST;
      nxt_s.tx_dis = 1'b0;
      nxt_s.fast_los = 1'b0;
      nxt_s.init_done = 1'b0;
      nxt_s.init_cnt = '0;
    end

    // Disable acts in one cycle; enable waits for the laser to settle
    if (nxt_s.tx_dis || !nxt_s.init_done) begin
      nxt_s.tx_on = 1'b0;
      nxt_s.txen_cnt = '0;
    end else if (!s_ff.tx_on && tick) begin
      if (s_ff.txen_cnt >= mfi_pkg::TXEN_TICKS - 1'b1) begin
        nxt_s.tx_on = 1'b1;
      end else begin
        nxt_s.txen_cnt = s_ff.txen_cnt + 1'b1;
      end
    end

    nxt_s.irq_oe = |(nxt_s.flag & ~nxt_s.mask);
    // Own flop so the init pin needs no gate after the register
    nxt_s.init_busy = ~nxt_s.init_done;
  end
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_ff <= S_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign AWREADY = s_ff.awrdy;
  assign WREADY = s_ff.wrdy;
  assign BVALID = s_ff.bvalid;
  assign BRESP = s_ff.bresp;
  assign ARREADY = s_ff.arrdy;
  assign RVALID = s_ff.rvalid;
  assign RDATA = {24'h000000, s_ff.rdata};
  assign RRESP = s_ff.rresp;
  // Open drain: only ever pulls low, the host pull-up gives the high
  assign INTERRUPT_OUT_N_O = s_ff.irq_lvl;
  assign INTERRUPT_OUT_N_OE = s_ff.irq_oe;
  assign MODULE_PRESENT_N = s_ff.pres_n;
  assign MANAGEMENT_INIT_STATE = s_ff.init_busy;
  assign TX_ENABLE = s_ff.tx_on;

  a_irq_level_match: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    s_ff.irq_oe == |(s_ff.flag & ~s_ff.mask))
    else $error("interrupt pin disagrees with unmasked flags");
  a_txf_sets_irq: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    ($rose(TX_FAULT_RAW) && MODULE_RESET_N &&
     !s_ff.mask[mfi_pkg::FLAG_TXF] && !ar_hs && !wr_go)
    |=> s_ff.flag[mfi_pkg::FLAG_TXF] && s_ff.irq_oe)
    else $error("tx fault did not raise flag and interrupt");
  a_other_flag_set: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (|(FLAG_COND & ~$past(FLAG_COND)) && MODULE_RESET_N)
    |=> |s_ff.flag[NF-1:mfi_pkg::FLAG_OTH])
    else $error("other condition did not set a flag");
  a_los_flag_set: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    ($rose(los_q) && MODULE_RESET_N) |=> s_ff.flag[mfi_pkg::FLAG_LOS])
    else $error("qualified loss of signal did not set its flag");
  a_flag_sticky: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (MODULE_RESET_N && !ar_hs && !wr_go)
    |=> (s_ff.flag & $past(s_ff.flag)) == $past(s_ff.flag))
    else $error("flag cleared without a host access");
  a_read_releases: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (ar_hs && ARADDR[4:2] == mfi_pkg::IDX_FLAG && set_v == '0)
    |=> s_ff.flag == '0 && !s_ff.irq_oe)
    else $error("flag read did not release the interrupt");
  a_mask_blocks: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    (&s_ff.mask) |-> !s_ff.irq_oe)
    else $error("masked flags still drive the interrupt");
  a_unmask_resumes: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    |(s_ff.flag & $past(s_ff.mask) & ~s_ff.mask) |-> s_ff.irq_oe)
    else $error("cleared mask did not resume the interrupt");
  a_txdis_off: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    s_ff.tx_dis |-> !s_ff.tx_on)
    else $error("transmitter on while disabled");
  a_txen_settle: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(s_ff.tx_on) |-> s_ff.init_done && !s_ff.tx_dis &&
    $past(s_ff.txen_cnt) == mfi_pkg::TXEN_TICKS - 1'b1)
    else $error("transmitter enabled without settle time");
  a_init_bound: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !s_ff.init_done |-> s_ff.init_cnt < mfi_pkg::INIT_TICKS)
    else $error("init counter ran past its limit");
  a_init_restart: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    $rose(MODULE_RESET_N) |-> !s_ff.init_done ##1 !s_ff.init_done)
    else $error("init did not restart after module reset");
  a_present_low: assert property (
    @(posedge CORE_CLK) disable iff (!NRST)
    !MODULE_PRESENT_N && !INTERRUPT_OUT_N_O)
    else $error("presence or interrupt drive level not low");
endmodule // mfi_top
`default_nettype wire

// [include/mfi_pkg.sv]
// Purpose: shared constants of the module flag and interrupt block
// Assumes: 125 MHz core clock, one millisecond tick for slow timing
// Notes: word indices on a 32-bit AXI4-Lite register bus, decoded from address bits 4:2
// Notes on behaviour
// - Management init completes within 2000 ms
// - Interrupt asserts within 200 ms of condition
// - Interrupt releases within 500 us of clear
// - LOS flag and interrupt within 100 ms
// - Fast mode LOS flag within 10 ms
// - LOS indication drops within 100 ms
// - Tx fault flag and interrupt within 200 ms
// - Other flags and interrupt within 200 ms
// - Set mask inhibits interrupt within 100 ms
// - Cleared mask resumes interrupt within 100 ms
// - Tx disable turns transmitter off quickly
// - Tx enable restores transmitter within 10 s
package mfi_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS;
  localparam int INIT_MAX_MS = 2000;
  localparam int RESET_MIN_US = 10;
  localparam int IRQ_ON_MAX_MS = 200;
  localparam int IRQ_OFF_MAX_US = 500;
  localparam int LOS_ON_MAX_MS = 100;
  localparam int LOS_FAST_MAX_MS = 10;
  localparam int LOS_OFF_MAX_MS = 100;
  localparam int MASK_MAX_MS = 100;
  localparam int TXDIS_MAX_MS = 100;
  localparam int TXEN_MAX_S = 10;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] INIT_TICKS = 12'd1000;
  localparam logic [CNT_W-1:0] LOS_ON_TICKS = 12'd50;
  localparam logic [CNT_W-1:0] LOS_FAST_TICKS = 12'd5;
  localparam logic [CNT_W-1:0] LOS_OFF_TICKS = 12'd50;
  localparam logic [CNT_W-1:0] TXEN_TICKS = 12'd10;
  localparam int NUM_OTHER = 6;
  localparam int NUM_FLAGS = 8;
  localparam int ADDR_W = 5;
  localparam logic [2:0] IDX_FLAG = 3'h0;
  localparam logic [2:0] IDX_MASK = 3'h1;
  localparam logic [2:0] IDX_CTRL = 3'h2;
  localparam logic [2:0] IDX_STATE = 3'h3;
  localparam int FLAG_LOS = 0;
  localparam int FLAG_TXF = 1;
  localparam int FLAG_OTH = 2;
  localparam int CTRL_TXDIS = 0;
  localparam int CTRL_FAST = 1;
  localparam int ST_INIT = 0;
  localparam int ST_TXON = 1;
  localparam int ST_LOS = 2;
  localparam int ST_PIN = 3;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verilog/mfi_tick.sv]
// Purpose: one-cycle millisecond enable from the core clock
// Assumes: DIV of at least 2
// Notes: free running, no restart on module reset
`timescale 1ns/1ps
`default_nettype none
module mfi_tick #(
  parameter int DIV = 125000
) (
  input wire logic core_clk,
  input wire logic nrst,
  output logic tick
);
  localparam int W = $clog2(DIV) + 1;
  typedef struct packed {
    logic tick;
    logic [W-1:0] cnt;
  } mfi_tick_st_t;
  mfi_tick_st_t s_ff;
  mfi_tick_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == W'(DIV - 1)) begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule // mfi_tick
`default_nettype wire

// [verilog/mfi_qual.sv]
// Purpose: level qualifier, input must differ for N ticks to flip
// Assumes: limits of at least 1 tick
// Notes: separate assert and release limits give hysteresis in time
`timescale 1ns/1ps
`default_nettype none
module mfi_qual #(
  parameter int CNT_W = 12
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic tick,
  input wire logic raw,
  input wire logic [CNT_W-1:0] on_ticks,
  input wire logic [CNT_W-1:0] off_ticks,
  output logic q
);
  typedef struct packed {
    logic q;
    logic [CNT_W-1:0] cnt;
  } mfi_qual_st_t;
  mfi_qual_st_t s_ff;
  mfi_qual_st_t nxt_s;
  logic [CNT_W-1:0] lim;

  always_comb begin
    nxt_s = s_ff;
    lim = raw ? on_ticks : off_ticks;
    if (clr) begin
      nxt_s = '0;
    end else if (raw == s_ff.q) begin
      nxt_s.cnt = '0;
    end else if (tick) begin
      if (s_ff.cnt >= lim - 1'b1) begin
        nxt_s.q = raw;
        nxt_s.cnt = '0;
      end else begin
        nxt_s.cnt = s_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.q;
endmodule // mfi_qual
`default_nettype wire

// [tb/mfi_host.sv]
// Purpose: host side of the interrupt wire and module reset pin
// Assumes: pull-up on the open-drain interrupt wire
// Notes: reset pulse length is counted in core clock cycles
`timescale 1ns/1ps
`default_nettype none
module mfi_host #(
  parameter int RST_CYC = 1250
) (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic drv_o,
  input wire logic drv_oe,
  output logic int_wire,
  output logic module_reset_n
);
  int cnt_ff = 0;
  // Released wire floats up to the pull-up level, never the last value
  assign int_wire = drv_oe ? drv_o : 1'b1;
  // Pulse of 10 us so that the module sees a full reset
  always @(posedge clk) begin
    if (rst_req) begin
      cnt_ff <= RST_CYC;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  assign module_reset_n = (cnt_ff == 0);
endmodule // mfi_host
`default_nettype wire

// [tb/mfi_top_test.sv]
// Purpose: self-checking bench of flags, mask and interrupt pin
// Assumes: ms tick shortened to T cycles
// Notes: bready and rready stay high, the bus answer ends every axw and axr wait
`timescale 1ns/1ps
`default_nettype none
module mfi_top_test;
  localparam int T = 10;
  localparam int IT = int'(mfi_pkg::INIT_TICKS);
  localparam int TXT = int'(mfi_pkg::TXEN_TICKS);
  localparam int LON = int'(mfi_pkg::LOS_ON_TICKS);
  localparam int LF = int'(mfi_pkg::LOS_FAST_TICKS);
  localparam int LOFF = int'(mfi_pkg::LOS_OFF_TICKS);
  localparam logic [4:0] A_FLAG = {mfi_pkg::IDX_FLAG, 2'b00};
  localparam logic [4:0] A_MASK = {mfi_pkg::IDX_MASK, 2'b00};
  localparam logic [4:0] A_CTRL = {mfi_pkg::IDX_CTRL, 2'b00};
  localparam logic [4:0] A_ST = {mfi_pkg::IDX_STATE, 2'b00};
  logic clk, nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic los = 1'b0, txf = 1'b0, rst_req = 1'b0;
  logic [5:0] flg = 6'h00;
  logic int_wire, mod_rst_n, oe, drv_o, present_n, init_st, tx_en;
  logic [31:0] d;
  logic [1:0] r;
  int errors = 0, n_compared = 0, k;

  mfi_top #(.TICK_CYCLES(T)) i_dut (
    .CORE_CLK(clk), .NRST(nrst),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hf),
    .BVALID(bvalid), .BREADY(1'b1), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
    .RVALID(rvalid), .RREADY(1'b1), .RDATA(rdata), .RRESP(rresp),
    .MODULE_RESET_N(mod_rst_n), .RX_LOS_RAW(los), .TX_FAULT_RAW(txf),
    .FLAG_COND(flg), .INTERRUPT_OUT_N_I(int_wire),
    .INTERRUPT_OUT_N_O(drv_o), .INTERRUPT_OUT_N_OE(oe),
    .MODULE_PRESENT_N(present_n), .MANAGEMENT_INIT_STATE(init_st),
    .TX_ENABLE(tx_en)
  );
  mfi_host i_host (
    .clk(clk), .rst_req(rst_req), .drv_o(drv_o), .drv_oe(oe),
    .int_wire(int_wire), .module_reset_n(mod_rst_n)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] v,
                     input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) begin
      errors++;
      summarize();
    end
    chk(bresp, er);
  endtask

  task automatic axr(input logic [4:0] a, output logic [31:0] v,
                     output logic [1:0] rr);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) begin
      errors++;
      summarize();
    end
    v = rdata;
    rr = rresp;
  endtask

  function automatic logic pin(input int s);
    case (s)
      0: return oe;
      1: return init_st;
      default: return tx_en;
    endcase
  endfunction

  // Waits for a pin level and checks the cycle count lies in [lo, hi)
  task automatic wt(input int s, input logic v, input int lo, input int hi);
    int n;
    for (n = 0; n < hi; n++) begin
      @(posedge clk);
      if (pin(s) === v) break;
    end
    if (n >= hi) begin
      errors++;
      summarize();
    end
    chk(n >= lo, 1);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk(present_n, 0);
    chk(init_st, 1);
    wt(1, 1'b0, (IT - 2) * T, (IT + 2) * T);
    axr(A_MASK, d, r);
    chk(d, 32'h0);
    wt(2, 1'b1, 0, (TXT + 2) * T);
    axw(A_CTRL, 32'h1, mfi_pkg::RESP_OKAY);
    chk(tx_en, 0);
    axw(A_CTRL, 32'h0, mfi_pkg::RESP_OKAY);
    wt(2, 1'b1, (TXT - 2) * T, (TXT + 2) * T);
    for (int i = 0; i < 6; i++) begin
      flg <= 6'h01 << i;
      wt(0, 1'b1, 0, 4);
      chk(int_wire, 0);
      axr(A_FLAG, d, r);
      chk(d, 32'h4 << i);
      chk(oe, 0);
      flg <= 6'h00;
      axr(A_FLAG, d, r);
      chk(d, 32'h0);
    end
    txf <= 1'b1;
    wt(0, 1'b1, 0, 4);
    axr(A_FLAG, d, r);
    chk(d, 32'h2);
    txf <= 1'b0;
    axw(A_MASK, 32'hff, mfi_pkg::RESP_OKAY);
    flg <= 6'h02;
    repeat (5) @(posedge clk);
    chk(oe, 0);
    axw(A_MASK, 32'h0, mfi_pkg::RESP_OKAY);
    chk(oe, 1);
    axr(A_FLAG, d, r);
    chk(d, 32'h8);
    // Two flags pending: clearing one must keep the pin low
    flg <= 6'h0c;
    wt(0, 1'b1, 0, 4);
    axw(A_FLAG, 32'h10, mfi_pkg::RESP_OKAY);
    chk(oe, 1);
    axr(A_FLAG, d, r);
    chk(d, 32'h20);
    chk(oe, 0);
    flg <= 6'h00;
    axw(5'h10, 32'h1, mfi_pkg::RESP_SLVERR);
    axr(5'h10, d, r);
    chk(d, 32'h0);
    chk(r, mfi_pkg::RESP_SLVERR);
    los <= 1'b1;
    wt(0, 1'b1, (LON - 1) * T, (LON + 2) * T);
    axr(A_FLAG, d, r);
    chk(d, 32'h1);
    los <= 1'b0;
    for (k = 0; k < LOFF + 3; k++) begin
      repeat (T) @(posedge clk);
      axr(A_ST, d, r);
      if (d[2] === 1'b0) break;
    end
    chk(d[2], 0);
    axw(A_CTRL, 32'h2, mfi_pkg::RESP_OKAY);
    los <= 1'b1;
    wt(0, 1'b1, (LF - 1) * T, (LF + 2) * T);
    axr(A_FLAG, d, r);
    chk(d, 32'h1);
    los <= 1'b0;
    axw(A_MASK, 32'h55, mfi_pkg::RESP_OKAY);
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk(init_st, 1);
    chk(tx_en, 0);
    repeat (1250) @(posedge clk);
    axr(A_MASK, d, r);
    chk(d, 32'h0);
    wt(1, 1'b0, (IT - 3) * T, (IT + 3) * T);
    summarize();
  end
endmodule // mfi_top_test
`default_nettype wire
